// *** led_lamp.sv ***
// Model: two-pin multicolor lamp counting pin transitions
`timescale 1ns/1ps
`default_nettype none

module led_lamp (
    input  wire logic        clk_sys,
    input  wire logic        led1_q,
    input  wire logic        led2_q,
    output logic      [15:0] tog1,
    output logic      [15:0] tog2,
    output logic      [1:0]  colour
);
    logic p1 = 1'b0;
    logic p2 = 1'b0;

    // Lit colour is the pair of pin levels
    assign colour = {led2_q, led1_q};

    // Count each change of pin level
    initial begin
        tog1 = 16'h0000;
        tog2 = 16'h0000;
    end
    always @(posedge clk_sys) begin
        tog1 <= tog1 + 16'(led1_q !== p1);
        tog2 <= tog2 + 16'(led2_q !== p2);
        p1   <= led1_q;
        p2   <= led2_q;
    end
endmodule

`default_nettype wire

// *** mcled_checker.sv ***
// Checker: port-level properties of the multicolor LED driver
`timescale 1ns/1ps
`default_nettype none

module mcled_checker #(
    parameter int STEP_CYC    = 4,
    parameter int ONE_SEC_CYC = 64
) (
    input  wire logic                    clk_sys,
    input  wire logic                    sys_rst,
    input  wire logic                    mgmt_wr,
    input  wire logic [4:0]              mgmt_addr,
    input  wire logic [15:0]             mgmt_wdata,
    input  wire logic [15:0]             mgmt_rdata,
    input  wire mcled_pkg::link_status_t link_status,
    input  wire logic                    led1_q,
    input  wire logic                    led2_q
);
    logic [11:0] sel_q;
    logic [8:0]  mode_q;
    logic [11:0] rate_q;
    logic [5:0]  blink_q;
    logic        last_q;
    logic [9:0]  run_q;
    logic [9:0]  stab_q;
    int          half;

    // Shadow decode of the register window
    wire       wr_data = mgmt_wr && mgmt_addr == 5'h15;
    wire [3:0] m1      = mode_q[3:0];
    wire [3:0] m2      = mode_q[7:4];
    wire       paired  = m1 == m2 && m1 inside {4'h0, 4'h2, 4'h3, 4'h6,
                                                4'h7, 4'h8, 4'h9, 4'hA};
    assign half = (int'(rate_q[11:6]) + 1) * STEP_CYC;

    // Shadow copies of the stored fields
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            sel_q   <= 12'h000;
            mode_q  <= 9'h000;
            rate_q  <= 12'h1C1;
            blink_q <= 6'h00;
        end else if (mgmt_wr) begin
            if (mgmt_addr == 5'h17) sel_q <= mgmt_wdata[11:0];
            if (wr_data && sel_q == 12'hF04) mode_q <= mgmt_wdata[8:0];
            if (wr_data && sel_q == 12'hF05) rate_q <= mgmt_wdata[11:0];
            if (wr_data && sel_q == 12'hF06) blink_q <= mgmt_wdata[5:0];
        end
    end

    // Run length of the first pin and time since the last data write
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            last_q <= 1'b0;
            run_q  <= 10'h000;
            stab_q <= 10'h000;
        end else begin
            last_q <= led1_q;
            run_q  <= (led1_q != last_q) ? 10'h001 : run_q + 10'h001;
            stab_q <= wr_data ? 10'h000 : stab_q + 10'(stab_q != 10'h3FF);
        end
    end

    ////////////////////////////////////////
    off_pin1_a:
        assert property (@(posedge clk_sys) disable iff (sys_rst)
            m1 == 4'h4 ##1 m1 == 4'h4 |=> !led1_q) else $error("pin one lit");
    on_pin2_a:
        assert property (@(posedge clk_sys) disable iff (sys_rst)
            m2 == 4'h5 ##1 m2 == 4'h5 |=> led2_q) else $error("pin two dark");
    pin_inverse_a:
        assert property (@(posedge clk_sys) disable iff (sys_rst)
            (paired && !mode_q[8]) [*2] |=> led2_q != led1_q)
            else $error("pins not inverse");
    pin_identical_a:
        assert property (@(posedge clk_sys) disable iff (sys_rst)
            (paired && mode_q[8]) [*2] |=> led2_q == led1_q)
            else $error("pins not identical");
    sel_readback_a:
        assert property (@(posedge clk_sys) disable iff (sys_rst)
            mgmt_addr == 5'h17 |=> mgmt_rdata == {4'h0, $past(sel_q)})
            else $error("selector readback wrong");
    mode_readback_a:
        assert property (@(posedge clk_sys) disable iff (sys_rst)
            sel_q == 12'hF04 && mgmt_addr == 5'h15 |=>
            mgmt_rdata[8:0] == $past(mode_q) && mgmt_rdata[15:10] == 6'h00)
            else $error("mode readback wrong");
    rate_readback_a:
        assert property (@(posedge clk_sys) disable iff (sys_rst)
            sel_q == 12'hF05 && mgmt_addr == 5'h15 |=>
            mgmt_rdata == {4'h0, $past(rate_q)}) else $error("rate readback");
    blink_readback_a:
        assert property (@(posedge clk_sys) disable iff (sys_rst)
            sel_q == 12'hF06 && mgmt_addr == 5'h15 |=>
            mgmt_rdata == {10'h000, $past(blink_q)}) else $error("blink rb");
    alt_run_a:
        assert property (@(posedge clk_sys) disable iff (sys_rst)
            m1 == 4'h6 && led1_q != last_q && int'(stab_q) > 2 * half + 4
            |-> int'(run_q) == half) else $error("alternating run wrong");
endmodule

bind multicolor_led_driver mcled_checker #(
    .STEP_CYC    (STEP_CYC),
    .ONE_SEC_CYC (ONE_SEC_CYC)
) u_chk (
    .clk_sys     (clk_sys),
    .sys_rst     (sys_rst),
    .mgmt_wr     (mgmt_wr),
    .mgmt_addr   (mgmt_addr),
    .mgmt_wdata  (mgmt_wdata),
    .mgmt_rdata  (mgmt_rdata),
    .link_status (link_status),
    .led1_q      (led1_q),
    .led2_q      (led2_q)
);

`default_nettype wire

// *** mcled_pkg.sv ***
// Package: constants and types for the multicolor LED driver
package mcled_pkg;

    // Clock and time base
    localparam int CLK_HZ      = 40_000_000;
    localparam int STEP_MS     = 21;
    localparam int STEP_CYC    = CLK_HZ / 1000 * STEP_MS;
    localparam int ONE_SEC_S   = 1;
    localparam int ONE_SEC_CYC = CLK_HZ * ONE_SEC_S;

    // Management register addresses
    localparam logic [4:0] ADDR_EXP_DATA   = 5'h15;
    localparam logic [4:0] ADDR_EXP_ACCESS = 5'h17;

    // Expansion selector values written to the access register
    localparam logic [11:0] SEL_MODE  = 12'hF04;
    localparam logic [11:0] SEL_RATE  = 12'hF05;
    localparam logic [11:0] SEL_BLINK = 12'hF06;

    // led_mode_select fields
    localparam int MODE_LED1_LSB = 0;
    localparam int MODE_LED2_LSB = 4;
    localparam int MODE_INPH_BIT = 8;
    localparam int MODE_FNOW_BIT = 9;

    // led_flash_rate_ctrl fields
    localparam int RATE_FLASH_LSB = 0;
    localparam int RATE_ALT_LSB   = 6;

    // led_blink_ctrl fields
    localparam int BLINK_RATE_LSB = 0;
    localparam int BLINK_UPD_BIT  = 5;

    // Reset values
    localparam logic [3:0] MODE_RST     = 4'h0;
    localparam logic [5:0] ALT_RATE_RST = 6'h07;
    localparam logic [5:0] FLS_RATE_RST = 6'h01;
    localparam logic [4:0] BLINK_RST    = 5'h00;

    // Pin modes
    typedef enum logic [3:0] {
        M_ENC_LINK_ACT = 4'h0,
        M_ENC_SPEED    = 4'h1,
        M_ACT_FLASH    = 4'h2,
        M_FULL_DUPLEX  = 4'h3,
        M_FORCE_OFF    = 4'h4,
        M_FORCE_ON     = 4'h5,
        M_ALTERNATE    = 4'h6,
        M_FLASHING     = 4'h7,
        M_LINK         = 4'h8,
        M_ACTIVITY     = 4'h9,
        M_PROG_BLINK   = 4'hA
    } led_mode_t;

    // Speed encoding of the transceiver core
    localparam logic [1:0] SPEED_1000 = 2'h2;

    // Status from the transceiver core
    typedef struct packed {
        logic       link_up;
        logic [1:0] speed;
        logic       activity;
        logic       full_duplex;
    } link_status_t;

    // Pattern sources feeding the per-pin mode selection
    typedef struct packed {
        logic link;
        logic act;
        logic gig;
        logic fdx;
        logic alt;
        logic flash;
        logic blink;
    } led_src_t;

    // Single-flash sequencer states
    typedef enum logic [1:0] {
        FS_IDLE = 2'b00,
        FS_ON   = 2'b01,
        FS_GAP  = 2'b10
    } flash_state_t;

endpackage

// *** multicolor_led_driver.sv ***
// Module: two-pin multicolor LED driver with expansion register window
//
// Behaviour
// - Bits 7:4 select the mode of the second LED pin from codes 0h..Ah.
// - Bits 3:0 select the mode of the first LED pin with the same codes.
// - Mode 0110 toggles the pin at 50% duty, 320 ms nominal period.
// - Mode 0111 toggles the pin with an 80 ms nominal period.
// - With equal modes other than 1h, 4h and 5h, bit 8 makes the pins identical, else inverse.
// - Flash-now gives one flash on each pin in mode 0111 only.
// - Flash-now is bit 9, resets to 0 and clears after the flash.
// - Bits 11:6 set alternating width and gap, reset value 07h.
// - The alternating rate only acts in mode 0110 at exactly 50% duty.
// - Bits 5:0 set flash width and gap in 21 ms steps, reset 01h.
// - Bits 4:0 give that many blinks per second, zero means none.
// - Bit 5 applies a new blink rate now, else at the 1 s timer.
// - F04h, F05h, F06h in the access register select the data window.
`timescale 1ns/1ps
`default_nettype none

module multicolor_led_driver #(
    parameter int STEP_CYC    = mcled_pkg::STEP_CYC,
    parameter int ONE_SEC_CYC = mcled_pkg::ONE_SEC_CYC
) (
    input  wire logic                    clk_sys,
    input  wire logic                    sys_rst,
    input  wire logic                    mgmt_wr,
    input  wire logic [4:0]              mgmt_addr,
    input  wire logic [15:0]             mgmt_wdata,
    output logic      [15:0]             mgmt_rdata,
    input  wire mcled_pkg::link_status_t link_status,
    output logic                         led1_q,
    output logic                         led2_q
);

    ////////////////////////////////////////////////////////////////////
    // Mode output selection, shared by both pins

    function automatic logic mode_out(input logic [3:0] m,
                                      input mcled_pkg::led_src_t s,
                                      input logic one);
        logic o;
        o = 1'b0;
        case (m)
            mcled_pkg::M_ENC_LINK_ACT: o = s.link & ~(s.act & s.flash);
            mcled_pkg::M_ENC_SPEED:    o = s.link & s.gig;
            mcled_pkg::M_ACT_FLASH:    o = s.act & s.flash;
            mcled_pkg::M_FULL_DUPLEX:  o = s.link & s.fdx;
            mcled_pkg::M_FORCE_OFF:    o = 1'b0;
            mcled_pkg::M_FORCE_ON:     o = 1'b1;
            mcled_pkg::M_ALTERNATE:    o = s.alt;
            mcled_pkg::M_FLASHING:     o = one;
            mcled_pkg::M_LINK:         o = s.link;
            mcled_pkg::M_ACTIVITY:     o = s.act;
            mcled_pkg::M_PROG_BLINK:   o = s.blink;
            default:                   o = 1'b0;
        endcase
        return o;
    endfunction

    // Modes in which the phase bit acts
    function automatic logic phase_mode(input logic [3:0] m);
        logic v;
        v = 1'b0;
        case (m)
            4'h0, 4'h2, 4'h3, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA: v = 1'b1;
            default: v = 1'b0;
        endcase
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Registers

    logic [11:0] exp_sel_q;
    logic [3:0]  mode1_q;
    logic [3:0]  mode2_q;
    logic        in_phase_q;
    logic        flash_now_q;
    logic        flash_now_d;
    logic [5:0]  alt_rate_q;
    logic [5:0]  flash_rate_q;
    logic [4:0]  blink_rate_q;
    logic        blink_upd_q;
    logic [4:0]  blink_act_q;
    logic [4:0]  blink_act_d;
    logic [15:0] rdata_q;
    logic [15:0] rdata_d;

    // Decode of the management window
    logic wr_access;
    logic wr_data;
    logic wr_mode;
    logic wr_rate;
    logic wr_blink;
    logic fnow_set;
    logic fnow_done;

    assign wr_access = mgmt_wr && (mgmt_addr == mcled_pkg::ADDR_EXP_ACCESS);
    assign wr_data   = mgmt_wr && (mgmt_addr == mcled_pkg::ADDR_EXP_DATA);
    assign wr_mode   = wr_data && (exp_sel_q == mcled_pkg::SEL_MODE);
    assign wr_rate   = wr_data && (exp_sel_q == mcled_pkg::SEL_RATE);
    assign wr_blink  = wr_data && (exp_sel_q == mcled_pkg::SEL_BLINK);

    // Flash-now: a software set wins over the self clear
    assign fnow_set    = wr_mode && mgmt_wdata[mcled_pkg::MODE_FNOW_BIT];
    assign flash_now_d = fnow_set ? 1'b1
                       : (fnow_done ? 1'b0 : flash_now_q);

    // Window read data, reserved bits read as zero
    logic [15:0] mode_word;
    logic [15:0] rate_word;
    logic [15:0] blink_word;
    logic [15:0] exp_word;

    assign mode_word  = {6'h00, flash_now_q, in_phase_q, mode2_q, mode1_q};
    assign rate_word  = {4'h0, alt_rate_q, flash_rate_q};
    assign blink_word = {10'h000, blink_upd_q, blink_rate_q};
    assign exp_word   = (exp_sel_q == mcled_pkg::SEL_MODE)  ? mode_word
                      : (exp_sel_q == mcled_pkg::SEL_RATE)  ? rate_word
                      : (exp_sel_q == mcled_pkg::SEL_BLINK) ? blink_word
                      : 16'h0000;
    assign rdata_d    = (mgmt_addr == mcled_pkg::ADDR_EXP_DATA) ? exp_word
                      : (mgmt_addr == mcled_pkg::ADDR_EXP_ACCESS)
                        ? {4'h0, exp_sel_q} : 16'h0000;
    assign mgmt_rdata = rdata_q;

    // Register writes, one field group per register
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            exp_sel_q    <= 12'h000;
            mode1_q      <= mcled_pkg::MODE_RST;
            mode2_q      <= mcled_pkg::MODE_RST;
            in_phase_q   <= 1'b0;
            alt_rate_q   <= mcled_pkg::ALT_RATE_RST;
            flash_rate_q <= mcled_pkg::FLS_RATE_RST;
            blink_rate_q <= mcled_pkg::BLINK_RST;
            blink_upd_q  <= 1'b0;
        end else begin
            if (wr_access) begin
                exp_sel_q <= mgmt_wdata[11:0];
            end
            if (wr_mode) begin
                mode1_q    <= mgmt_wdata[mcled_pkg::MODE_LED1_LSB +: 4];
                mode2_q    <= mgmt_wdata[mcled_pkg::MODE_LED2_LSB +: 4];
                in_phase_q <= mgmt_wdata[mcled_pkg::MODE_INPH_BIT];
            end
            if (wr_rate) begin
                alt_rate_q   <= mgmt_wdata[mcled_pkg::RATE_ALT_LSB +: 6];
                flash_rate_q <= mgmt_wdata[mcled_pkg::RATE_FLASH_LSB +: 6];
            end
            if (wr_blink) begin
                blink_rate_q <= mgmt_wdata[mcled_pkg::BLINK_RATE_LSB +: 5];
                blink_upd_q  <= mgmt_wdata[mcled_pkg::BLINK_UPD_BIT];
            end
        end
    end

    // Flash-now flag and registered read data
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            flash_now_q <= 1'b0;
            rdata_q     <= 16'h0000;
        end else begin
            flash_now_q <= flash_now_d;
            rdata_q     <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // 21 ms step tick and 1 s interval timer

    localparam int SW = $clog2(STEP_CYC);
    localparam int TW = $clog2(ONE_SEC_CYC) + 1;
    localparam logic [SW-1:0] STEP_LAST = SW'(STEP_CYC - 1);
    localparam logic [TW-1:0] SEC_LAST  = TW'(ONE_SEC_CYC - 1);
    localparam logic [TW-1:0] SEC_LEN   = TW'(ONE_SEC_CYC);

    logic [SW-1:0] step_cnt_q;
    logic [TW-1:0] sec_cnt_q;
    logic          step_tick;
    logic          sec_tick;

    assign step_tick = (step_cnt_q == STEP_LAST);
    assign sec_tick  = (sec_cnt_q == SEC_LAST);

    // Free-running dividers
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            step_cnt_q <= '0;
            sec_cnt_q  <= '0;
        end else begin
            step_cnt_q <= step_tick ? '0 : step_cnt_q + SW'(1);
            sec_cnt_q  <= sec_tick ? '0 : sec_cnt_q + TW'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Alternating and flashing patterns

    logic alt_phase;
    logic flash_phase;

    // Half period (alt_rate+1) steps, 50% duty
    step_toggler u_alt (
        .clk_sys   (clk_sys),
        .sys_rst   (sys_rst),
        .step_tick (step_tick),
        .code      (alt_rate_q),
        .phase_q   (alt_phase)
    );

    // Width and gap (flash_rate+1) steps each
    step_toggler u_flash (
        .clk_sys   (clk_sys),
        .sys_rst   (sys_rst),
        .step_tick (step_tick),
        .code      (flash_rate_q),
        .phase_q   (flash_phase)
    );

    ////////////////////////////////////////////////////////////////////
    // Single flash sequencer

    mcled_pkg::flash_state_t fs_q;
    mcled_pkg::flash_state_t fs_d;
    logic [5:0]              fs_cnt_q;
    logic [5:0]              fs_cnt_d;
    logic                    fs_end;

    assign fs_end    = step_tick && (fs_cnt_q >= flash_rate_q);
    assign fnow_done = (fs_q == mcled_pkg::FS_GAP) && fs_end;

    // One on-width then one gap, then back to the free pattern
    always_comb begin
        fs_d     = fs_q;
        fs_cnt_d = step_tick ? fs_cnt_q + 6'h01 : fs_cnt_q;
        case (fs_q)
            mcled_pkg::FS_IDLE: begin
                fs_cnt_d = 6'h00;
                if (flash_now_q) begin
                    fs_d = mcled_pkg::FS_ON;
                end
            end
            mcled_pkg::FS_ON: begin
                if (fs_end) begin
                    fs_d     = mcled_pkg::FS_GAP;
                    fs_cnt_d = 6'h00;
                end
            end
            mcled_pkg::FS_GAP: begin
                if (fs_end) begin
                    fs_d     = mcled_pkg::FS_IDLE;
                    fs_cnt_d = 6'h00;
                end
            end
            default: begin
                fs_d     = mcled_pkg::FS_IDLE;
                fs_cnt_d = 6'h00;
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            fs_q     <= mcled_pkg::FS_IDLE;
            fs_cnt_q <= 6'h00;
        end else begin
            fs_q     <= fs_d;
            fs_cnt_q <= fs_cnt_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Programmable blink

    logic [TW-1:0] blink_acc_q;
    logic [TW-1:0] blink_acc_d;
    logic [TW-1:0] blink_sum;
    logic          blink_wrap;
    logic          blink_phase_q;

    // Deferred or immediate take-over of the blink rate
    assign blink_act_d = (blink_upd_q || sec_tick)
                       ? blink_rate_q : blink_act_q;

    // Add two edges per blink each cycle, toggle per second's worth
    assign blink_sum   = blink_acc_q + TW'({blink_act_q, 1'b0});
    assign blink_wrap  = (blink_sum >= SEC_LEN);
    assign blink_acc_d = (blink_act_q == 5'h00) ? '0
                       : (blink_wrap ? blink_sum - SEC_LEN : blink_sum);

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            blink_act_q   <= mcled_pkg::BLINK_RST;
            blink_acc_q   <= '0;
            blink_phase_q <= 1'b0;
        end else begin
            blink_act_q   <= blink_act_d;
            blink_acc_q   <= blink_acc_d;
            if (blink_act_q == 5'h00) begin
                blink_phase_q <= 1'b0;
            end else if (blink_wrap) begin
                blink_phase_q <= ~blink_phase_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Activity stretch and pin outputs

    logic act_hold_q;
    logic flash_prev_q;
    logic flash_fall;

    // Hold activity until the next falling edge of the flash pattern
    assign flash_fall = flash_prev_q && !flash_phase;

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            act_hold_q   <= 1'b0;
            flash_prev_q <= 1'b0;
        end else begin
            flash_prev_q <= flash_phase;
            if (link_status.activity) begin
                act_hold_q <= 1'b1;
            end else if (flash_fall) begin
                act_hold_q <= 1'b0;
            end
        end
    end

    mcled_pkg::led_src_t src;
    logic                flash_src;
    logic                same_mode;
    logic                led1_d;
    logic                led2_d;

    // One-shot overrides the free flash pattern, for mode 0111 pins only
    assign flash_src = (fs_q == mcled_pkg::FS_IDLE) ? flash_phase
                     : (fs_q == mcled_pkg::FS_ON);
    assign src.link  = link_status.link_up;
    assign src.act   = act_hold_q;
    assign src.gig   = (link_status.speed == mcled_pkg::SPEED_1000);
    assign src.fdx   = link_status.full_duplex;
    assign src.alt   = alt_phase;
    assign src.flash = flash_phase;
    assign src.blink = blink_phase_q;

    assign same_mode = (mode1_q == mode2_q) && phase_mode(mode1_q);
    assign led1_d    = mode_out(mode1_q, src, flash_src);
    assign led2_d    = (same_mode && !in_phase_q)
                     ? ~mode_out(mode2_q, src, flash_src)
                     : mode_out(mode2_q, src, flash_src);

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            led1_q <= 1'b0;
            led2_q <= 1'b0;
        end else begin
            led1_q <= led1_d;
            led2_q <= led2_d;
        end
    end

endmodule

`default_nettype wire

// *** step_toggler.sv ***
// Module: square wave whose half period is (code+1) step ticks
`timescale 1ns/1ps
`default_nettype none

module step_toggler (
    input  wire logic       clk_sys,
    input  wire logic       sys_rst,
    input  wire logic       step_tick,
    input  wire logic [5:0] code,
    output logic            phase_q
);

    logic [5:0] cnt_q;
    logic [5:0] cnt_d;
    logic       wrap;
    logic       phase_d;

    // Count steps, flip the phase after code+1 of them
    assign wrap    = step_tick && (cnt_q >= code);
    assign cnt_d   = wrap ? 6'h00 : (step_tick ? cnt_q + 6'h01 : cnt_q);
    assign phase_d = wrap ? ~phase_q : phase_q;

    // Equal on and off halves give an exact 50% duty cycle
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_q   <= 6'h00;
            phase_q <= 1'b0;
        end else begin
            cnt_q   <= cnt_d;
            phase_q <= phase_d;
        end
    end

endmodule

`default_nettype wire

// *** tb_top.sv ***
// Testbench: register window and LED pattern checks
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    localparam int STEP = 4;
    localparam int SEC  = 64;
    localparam logic [5:0] SEXP = 6'b011011;
    logic [3:0] smode [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h8, 4'h9};
    logic [4:0] brate [3] = '{5'h01, 5'h02, 5'h1F};
    logic        clk_sys    = 1'b0;
    logic        sys_rst    = 1'b1;
    logic        mgmt_wr    = 1'b0;
    logic [4:0]  mgmt_addr  = 5'h00;
    logic [15:0] mgmt_wdata = 16'h0000;
    logic [15:0] mgmt_rdata;
    logic        led1_q;
    logic        led2_q;
    logic [15:0] tog1;
    logic [15:0] tog2;
    logic [15:0] d;
    logic [15:0] t0;
    mcled_pkg::link_status_t link_status = '0;
    int          err_total = 0;
    int          checked   = 0;
    int          n;

    // Clock and design under test
    always #12.5 clk_sys = ~clk_sys;
    multicolor_led_driver #(.STEP_CYC(STEP), .ONE_SEC_CYC(SEC)) DUT (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .mgmt_wr(mgmt_wr),
        .mgmt_addr(mgmt_addr), .mgmt_wdata(mgmt_wdata),
        .mgmt_rdata(mgmt_rdata), .link_status(link_status),
        .led1_q(led1_q), .led2_q(led2_q));
    led_lamp lamp (.clk_sys(clk_sys), .led1_q(led1_q), .led2_q(led2_q),
        .tog1(tog1), .tog2(tog2), .colour());

    ////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_sim;
        $display("Checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] v);
        @(posedge clk_sys);
        mgmt_wr    <= 1'b1;
        mgmt_addr  <= a;
        mgmt_wdata <= v;
        @(posedge clk_sys);
        mgmt_wr    <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a);
        @(posedge clk_sys);
        mgmt_addr <= a;
        cyc(1);
        d = mgmt_rdata;
    endtask
    task automatic xw(input logic [11:0] s, input logic [15:0] v);
        wr(5'h17, {4'h0, s});
        wr(5'h15, v);
    endtask
    task automatic xr(input logic [11:0] s, input logic [15:0] exp);
        wr(5'h17, {4'h0, s});
        rd(5'h15);
        check(d, exp);
    endtask
    // Skip the mode switch and a partial level, then time one full level
    task automatic run1(input int exp);
        int c;
        logic v;
        #1;
        for (int j = 0; j < 3; j++) begin
            c = 0;
            v = led1_q;
            while (led1_q === v && c < 2000) begin cyc(1); c++; end
        end
        check(16'(c), 16'(exp));
    endtask

    ////////////////////////////////////////
    // Watchdog
    initial begin
        #500000;
        err_total++;
        end_sim();
    end

    // Main sequence
    initial begin
        repeat (16) @(posedge clk_sys);
        sys_rst <= 1'b0;
        xr(12'hF04, 16'h0000);
        xr(12'hF05, 16'h01C1);
        xr(12'hF06, 16'h0000);
        xr(12'hF08, 16'h0000);
        rd(5'h17);
        check(d, 16'h0F08);
        wr(5'h10, 16'h0FFF);
        xr(12'hF05, 16'h01C1);
        xw(12'hF05, 16'h0FFF);
        xr(12'hF05, 16'h0FFF);
        xw(12'hF06, 16'h003F);
        xr(12'hF06, 16'h003F);
        xw(12'hF04, 16'h01AA);
        xr(12'hF04, 16'h01AA);
        for (int i = 0; i < 4; i++) begin
            xw(12'hF04, {8'h00, 3'h2, i[1], 3'h2, i[0]});
            cyc(3);
            check({14'h0, led2_q, led1_q}, {14'h0, i[1:0]});
        end
        link_status <= 5'h19;
        for (int k = 0; k < 12; k++) begin
            if (k == 6) link_status <= 5'h00;
            xw(12'hF04, {8'h00, 4'h4, smode[k % 6]});
            cyc(3);
            check({15'h0, led1_q}, {15'h0, k < 6 && SEXP[k % 6]});
        end
        xw(12'hF05, 16'h0000);
        xw(12'hF04, 16'h0066);
        run1(STEP);
        check({15'h0, led2_q}, {15'h0, ~led1_q});
        xw(12'hF04, 16'h0166);
        cyc(3);
        check({15'h0, led2_q}, {15'h0, led1_q});
        xw(12'hF05, 16'h0080);
        xw(12'hF04, 16'h0056);
        run1(3 * STEP);
        check({15'h0, led2_q}, 16'h0001);
        xw(12'hF05, 16'h0001);
        xw(12'hF04, 16'h0047);
        run1(2 * STEP);
        for (int f = 0; f < 2; f++) begin
            xw(12'hF04, f ? 16'h0244 : 16'h0247);
            rd(5'h15);
            check(d, f ? 16'h0244 : 16'h0247);
            check({15'h0, led1_q}, {15'h0, f == 0});
            n = 0;
            while (d[9] === 1'b1 && n < 40) begin rd(5'h15); n++; end
            check(d, f ? 16'h0044 : 16'h0047);
            check(16'(n <= 12), 16'h0001);
        end
        check({14'h0, led2_q, led1_q}, 16'h0000);
        xw(12'hF04, 16'h004A);
        for (int r = 0; r < 3; r++) begin
            xw(12'hF06, {11'h001, brate[r]});
            cyc(4);
            t0 = tog1;
            cyc(SEC);
            check(tog1 - t0, 16'(2 * brate[r]));
        end
        xw(12'hF06, 16'h0020);
        cyc(4);
        t0 = tog1;
        cyc(SEC);
        check({tog1 - t0}, 16'h0000);
        check({15'h0, led1_q}, 16'h0000);
        xw(12'hF06, 16'h0004);
        cyc(SEC + 4);
        t0 = tog1;
        cyc(SEC);
        check(tog1 - t0, 16'h0008);
        end_sim();
    end
endmodule

`default_nettype wire
